// ### acr_config_regs.sv
`timescale 1ns/1ps
`include "acr_defines.svh"
// Function
// R01 - Normal mode rate codes 000..110 give 20 to 1000 SPS; 111 reserved.
// R02 - Turbo mode rate codes 000..110 give 40 to 2000 SPS; 111 reserved.
// R03 - Speed bit 4 of register 1: 0 normal 256 kHz, 1 turbo 512 kHz.
// R04 - Bit 3 of register 1: 0 single-shot, 1 continuous conversions.
// R05 - Reference: 00 internal, 01 external pins, 10 and 11 analog supply.
// R06 - Temperature mode uses internal reference and ignores register 0.
// R07 - Bit 7 of register 2 flags a new result, cleared on data read.
// R08 - Bit 6 of register 2 enables the conversion result counter.
// R09 - Integrity: 00 off, 01 inverted data, 10 CRC16, 11 reserved.
// R10 - Bit 3 of register 2 switches the 10 uA burn-out sources.
// R11 - Excitation current code 000 off through 110 at 1000 uA.
// R12 - Bits 7:5 of register 3 route the first excitation source.
// R13 - Bits 4:2 of register 3 route the second source likewise.
// R14 - Host writes zero to reserved bit 1 of register 3; reads zero.
// R15 - Bit 0 of register 3: 0 manual reading, 1 automatic result sending.
// R16 - Registers 1, 2, 3 sit at addresses 01h, 02h, 03h, reset 00h.
// R17 - Writes leave the ready flag and reserved bit unchanged.
module acr_config_regs
  import acr_pkg::*;
#(
  parameter int MOD_DIV_NORMAL = `ACR_MOD_DIV_NORMAL,
  parameter int MOD_DIV_TURBO = `ACR_MOD_DIV_TURBO,
  parameter int CONV_SHIFT = 0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic conv_start,
  input wire logic result_read,
  output acr_ctrl_t ctrl,
  output logic mod_tick,
  output logic conv_busy,
  output logic result_ready_flag,
  output logic new_result,
  output logic auto_send,
  output logic [7:0] result_count
);

  // The divider must give a real gap between modulator ticks
  if (MOD_DIV_TURBO < 9 || MOD_DIV_NORMAL < MOD_DIV_TURBO || MOD_DIV_NORMAL > 127)
  begin : g_chk
    $error("Modulator divider values not supported");
  end

  localparam logic [6:0] DIV_N_LAST = 7'(MOD_DIV_NORMAL - 1);
  localparam logic [6:0] DIV_T_LAST = 7'(MOD_DIV_TURBO - 1);

  acr_cfg1_t cfg1_ff;
  acr_cfg2_t cfg2_ff;
  acr_cfg3_t cfg3_ff;
  logic ready_ff;
  logic [7:0] rdata_ff;
  acr_ctrl_t ctrl_ff;
  logic [6:0] div_cnt_ff;
  logic mod_tick_ff;
  logic busy_ff;
  logic new_result_ff;
  logic auto_send_ff;
  logic [7:0] count_ff;
  logic conv_done;
  logic conv_running;
  logic rate_ok;

  // Source routing shared by both excitation outputs; 111 acts as disabled
  function automatic logic [5:0] route_onehot(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h00;
    case (code)
      3'h1: r = 6'h01;
      3'h2: r = 6'h02;
      3'h3: r = 6'h04;
      3'h4: r = 6'h08;
      3'h5: r = 6'h10;
      3'h6: r = 6'h20;
      default: r = 6'h00;
    endcase
    return r;
  endfunction : route_onehot

  // Normal-mode rate; turbo doubles every entry
  function automatic logic [10:0] sps_normal(input logic [2:0] code);
    logic [10:0] s;
    s = 11'h000;
    case (code)
      3'h0: s = 11'h014;
      3'h1: s = 11'h02D;
      3'h2: s = 11'h05A;
      3'h3: s = 11'h0AF;
      3'h4: s = 11'h14A;
      3'h5: s = 11'h258;
      3'h6: s = 11'h3E8;
      default: s = 11'h000;
    endcase
    return s;
  endfunction : sps_normal

  assign rate_ok = (cfg1_ff.sample_rate_code != 3'h7);

  // Register writes; reset puts all three at zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg1_ff <= `ACR_CFG_RESET; // see R16
      cfg2_ff <= `ACR_CFG_RESET; // see R16
      cfg3_ff <= `ACR_CFG_RESET; // see R16
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ACR_ADDR_CFG1: cfg1_ff <= reg_wdata & `ACR_CFG1_WMASK; // see R16
        `ACR_ADDR_CFG2: cfg2_ff <= reg_wdata & `ACR_CFG2_WMASK; // see R17
        `ACR_ADDR_CFG3: cfg3_ff <= reg_wdata & `ACR_CFG3_WMASK; // see R14
        default: cfg1_ff <= cfg1_ff;
      endcase
    end
  end

  // Ready flag: a new result in the same cycle as a read keeps it set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ready_ff <= 1'b0;
    else if (conv_done)
      ready_ff <= 1'b1; // see R07
    else if (result_read)
      ready_ff <= 1'b0; // see R07
  end

  // Read-back; unmapped addresses answer zero, reserved bit reads zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ACR_ADDR_CFG1: rdata_ff <= cfg1_ff;
        `ACR_ADDR_CFG2: rdata_ff <= {ready_ff, cfg2_ff[6:0]}; // see R07
        `ACR_ADDR_CFG3: rdata_ff <= {cfg3_ff[7:2], 1'b0, cfg3_ff.auto_out}; // see R14
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // Modulator clock enable; on a speed change the divider keeps its count and wraps once it reaches the new limit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt_ff <= 7'h00;
      mod_tick_ff <= 1'b0;
    end
    else if (div_cnt_ff >= (cfg1_ff.turbo ? DIV_T_LAST : DIV_N_LAST)) // see R03
    begin
      div_cnt_ff <= 7'h00;
      mod_tick_ff <= 1'b1;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
      mod_tick_ff <= 1'b0;
    end
  end

  // Conversion timing lives in the small timer module
  acr_conv_timer #(
    .CONV_SHIFT(CONV_SHIFT)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .mod_tick(mod_tick_ff),
    .rate_code(cfg1_ff.sample_rate_code),
    .rate_valid(rate_ok),
    .start(conv_start),
    .continuous(cfg1_ff.conversion_continuous_sel), // see R04
    .done(conv_done),
    .busy(conv_running)
  );

  // Result events, counter and automatic sending
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      new_result_ff <= 1'b0;
      auto_send_ff <= 1'b0;
      count_ff <= 8'h00;
    end
    else
    begin
      busy_ff <= conv_running;
      new_result_ff <= conv_done;
      auto_send_ff <= conv_done && cfg3_ff.auto_out; // see R15
      if (conv_done && cfg2_ff.result_counter_enable)
        count_ff <= count_ff + 1'b1; // see R08
    end
  end

  // Decoded settings, registered so every output comes from a flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_ff <= '0;
    else
    begin
      ctrl_ff.rate_valid <= rate_ok; // see R01
      if (!cfg1_ff.turbo)
        ctrl_ff.sps <= sps_normal(cfg1_ff.sample_rate_code); // see R01
      else
        ctrl_ff.sps <= sps_normal(cfg1_ff.sample_rate_code) << 1; // see R02
      ctrl_ff.turbo <= cfg1_ff.turbo; // see R03
      ctrl_ff.continuous <= cfg1_ff.conversion_continuous_sel; // see R04
      ctrl_ff.temp_mode <= cfg1_ff.temp_sensor_mode;
      ctrl_ff.reg0_ignored <= cfg1_ff.temp_sensor_mode; // see R06
      // Temperature mode overrides any reference choice
      if (cfg1_ff.temp_sensor_mode || cfg1_ff.vref == 2'h0)
        ctrl_ff.ref_src <= ACR_REF_INTERNAL; // see R06
      else if (cfg1_ff.vref == 2'h1)
        ctrl_ff.ref_src <= ACR_REF_EXTERNAL; // see R05
      else
        ctrl_ff.ref_src <= ACR_REF_SUPPLY; // see R05
      ctrl_ff.cnt_en <= cfg2_ff.result_counter_enable; // see R08
      // Reserved integrity code is treated as checking off
      case (cfg2_ff.integrity)
        2'h1: ctrl_ff.integ <= ACR_INTEG_INVERT; // see R09
        2'h2: ctrl_ff.integ <= ACR_INTEG_CRC16; // see R09
        default: ctrl_ff.integ <= ACR_INTEG_OFF; // see R09
      endcase
      ctrl_ff.burnout_on <= cfg2_ff.burnout_source_enable; // see R10
      ctrl_ff.burnout_ua <= cfg2_ff.burnout_source_enable ? `ACR_BURNOUT_UA : 11'h000; // see R10
      case (cfg2_ff.excitation_current_code)
        3'h1: ctrl_ff.current_ua <= 11'h00A; // see R11
        3'h2: ctrl_ff.current_ua <= 11'h032;
        3'h3: ctrl_ff.current_ua <= 11'h064;
        3'h4: ctrl_ff.current_ua <= 11'h0FA;
        3'h5: ctrl_ff.current_ua <= 11'h1F4;
        3'h6: ctrl_ff.current_ua <= 11'h3E8;
        default: ctrl_ff.current_ua <= 11'h000;
      endcase
      ctrl_ff.route1 <= route_onehot(cfg3_ff.first_source_route); // see R12
      ctrl_ff.route2 <= route_onehot(cfg3_ff.second_source_route); // see R13
      ctrl_ff.auto_out <= cfg3_ff.auto_out; // see R15
    end
  end

  assign reg_rdata = rdata_ff;
  assign ctrl = ctrl_ff;
  assign mod_tick = mod_tick_ff;
  assign conv_busy = busy_ff;
  assign result_ready_flag = ready_ff;
  assign new_result = new_result_ff;
  assign auto_send = auto_send_ff;
  assign result_count = count_ff;

  // Checks on the decoded outputs and the flag behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_rate_normal_20: assert property ( // see R01
    reg_wr && reg_addr == `ACR_ADDR_CFG1 && reg_wdata[7:4] == 4'h0 ##1 !reg_wr |=> ctrl_ff.sps == 11'h014)
    else $error("normal code 000 not 20 SPS");
  a_rate_turbo_2000: assert property ( // see R02
    reg_wr && reg_addr == `ACR_ADDR_CFG1 && reg_wdata[7:4] == 4'hD ##1 !reg_wr |=> ctrl_ff.sps == 11'h7D0)
    else $error("turbo code 110 not 2000 SPS");
  a_mod_tick_gap: assert property ( // see R03
    mod_tick_ff |=> !mod_tick_ff [*8])
    else $error("modulator ticks too close");
  a_single_stops: assert property ( // see R04
    conv_done && !cfg1_ff.conversion_continuous_sel && !conv_start |=> !conv_running ##1 !busy_ff)
    else $error("single-shot conversion kept running");
  a_ref_supply: assert property ( // see R05
    reg_wr && reg_addr == `ACR_ADDR_CFG1 && reg_wdata[2:0] == 3'h6 ##1 !reg_wr |=> ctrl_ff.ref_src == ACR_REF_SUPPLY)
    else $error("reference code 11 not supply");
  a_temp_ref: assert property ( // see R06
    $rose(ctrl_ff.temp_mode) |-> ctrl_ff.ref_src == ACR_REF_INTERNAL && ctrl_ff.reg0_ignored)
    else $error("temperature mode not on internal reference");
  a_ready_set: assert property ( // see R07
    conv_done |=> ready_ff && new_result_ff)
    else $error("result flag not set by a new result");
  a_ready_clear: assert property ( // see R07
    result_read && !conv_done |=> !ready_ff)
    else $error("result flag not cleared by data read");
  a_count_gate: assert property ( // see R08
    conv_done |=> count_ff == $past(count_ff) + 8'($past(cfg2_ff.result_counter_enable)))
    else $error("result counter ignored its enable");
  a_integ_crc: assert property ( // see R09
    reg_wr && reg_addr == `ACR_ADDR_CFG2 && reg_wdata[5:4] == 2'h2 ##1 !reg_wr |=> ctrl_ff.integ == ACR_INTEG_CRC16)
    else $error("integrity code 10 not CRC16");
  a_burnout_on: assert property ( // see R10
    reg_wr && reg_addr == `ACR_ADDR_CFG2 ##1 !reg_wr |=> ctrl_ff.burnout_on == $past(reg_wdata[3], 2))
    else $error("burn-out sources do not follow bit 3");
  a_current_max: assert property ( // see R11
    reg_wr && reg_addr == `ACR_ADDR_CFG2 && reg_wdata[2:0] == 3'h6 ##1 !reg_wr |=> ctrl_ff.current_ua == 11'h3E8)
    else $error("current code 110 not 1000 uA");
  a_route1_ref_pos_pin: assert property ( // see R12
    reg_wr && reg_addr == `ACR_ADDR_CFG3 && reg_wdata[7:5] == 3'h5 ##1 !reg_wr |=> ctrl_ff.route1 == 6'h10)
    else $error("first source not on positive reference pin");
  a_route2_ref_neg_pin: assert property ( // see R13
    reg_wr && reg_addr == `ACR_ADDR_CFG3 && reg_wdata[4:2] == 3'h6 ##1 !reg_wr |=> ctrl_ff.route2 == 6'h20)
    else $error("second source not on negative reference pin");
  a_rsvd_zero: assert property ( // see R14
    reg_rd && reg_addr == `ACR_ADDR_CFG3 |=> !rdata_ff[`ACR_RSVD_BIT])
    else $error("reserved bit read back as one");
  a_auto_send: assert property ( // see R15
    conv_done |=> auto_send_ff == $past(cfg3_ff.auto_out))
    else $error("automatic sending does not follow output mode");
  a_flag_kept: assert property ( // see R17
    reg_wr && reg_addr == `ACR_ADDR_CFG2 && !conv_done && !result_read |=> ready_ff == $past(ready_ff))
    else $error("write disturbed the result flag");
  a_cfg1_store: assert property ( // see R16
    reg_wr && reg_addr == `ACR_ADDR_CFG1 |=> cfg1_ff == $past(reg_wdata))
    else $error("register 1 write did not land");
  a_unmapped_zero: assert property ( // see R16
    reg_rd && (reg_addr == 8'h00 || reg_addr > `ACR_ADDR_CFG3) |=> rdata_ff == 8'h00)
    else $error("unmapped address read back nonzero");
  a_rate_refused: assert property ( // see R01
    conv_start && !rate_ok && !conv_running |=> !conv_running)
    else $error("start accepted with reserved rate");
  a_cont_rerun: assert property ( // see R04
    conv_done && $past(cfg1_ff.conversion_continuous_sel) && $past(rate_ok) |-> conv_running)
    else $error("continuous conversion stopped");
  a_auto_quiet: assert property ( // see R15
    !cfg3_ff.auto_out |=> !auto_send_ff)
    else $error("automatic sending while in manual mode");

  c_continuous: cover property (conv_done && cfg1_ff.conversion_continuous_sel ##1 conv_running);
  c_auto_send: cover property (auto_send_ff);
  c_set_and_read: cover property (conv_done && result_read);
  c_turbo_tick: cover property (cfg1_ff.turbo && mod_tick_ff);
  c_flag_write: cover property (reg_wr && reg_addr == `ACR_ADDR_CFG2 && ready_ff);

endmodule : acr_config_regs

// ### acr_defines.svh
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// Register addresses on the command side and their reset value
`define ACR_ADDR_CFG1 8'h01
`define ACR_ADDR_CFG2 8'h02
`define ACR_ADDR_CFG3 8'h03
`define ACR_CFG_RESET 8'h00

// Writable bits; flag and reserved bits are masked off
`define ACR_CFG1_WMASK 8'hFF
`define ACR_CFG2_WMASK 8'h7F
`define ACR_CFG3_WMASK 8'hFD

// Field positions inside the three registers
`define ACR_READY_BIT 7
`define ACR_RSVD_BIT 1

// Clock and modulator timing
`define ACR_CLK_HZ 25000000
`define ACR_MOD_NORMAL_HZ 256000
`define ACR_MOD_TURBO_HZ 512000
`define ACR_MOD_DIV_NORMAL (`ACR_CLK_HZ / `ACR_MOD_NORMAL_HZ)
`define ACR_MOD_DIV_TURBO (`ACR_CLK_HZ / `ACR_MOD_TURBO_HZ)

// Modulator ticks per conversion, same for both speed modes
`define ACR_TICKS_W 14
`define ACR_TICKS_0 14'h3200
`define ACR_TICKS_1 14'h1638
`define ACR_TICKS_2 14'h0B1C
`define ACR_TICKS_3 14'h05B6
`define ACR_TICKS_4 14'h0307
`define ACR_TICKS_5 14'h01AA
`define ACR_TICKS_6 14'h0100

// Analog figures reported in the decoded control word
`define ACR_BURNOUT_UA 11'h00A

`endif

// ### acr_pkg.sv
package acr_pkg;

  typedef struct packed {
    logic [2:0] sample_rate_code;
    logic turbo;
    logic conversion_continuous_sel;
    logic [1:0] vref;
    logic temp_sensor_mode;
  } acr_cfg1_t;

  typedef struct packed {
    logic result_ready_flag;
    logic result_counter_enable;
    logic [1:0] integrity;
    logic burnout_source_enable;
    logic [2:0] excitation_current_code;
  } acr_cfg2_t;

  typedef struct packed {
    logic [2:0] first_source_route;
    logic [2:0] second_source_route;
    logic rsvd;
    logic auto_out;
  } acr_cfg3_t;

  typedef enum logic [1:0] {ACR_REF_INTERNAL, ACR_REF_EXTERNAL, ACR_REF_SUPPLY} acr_ref_t;
  typedef enum logic [1:0] {ACR_INTEG_OFF, ACR_INTEG_INVERT, ACR_INTEG_CRC16} acr_integ_t;
  typedef enum logic {ACR_IDLE, ACR_RUN} acr_seq_t;

  // Decoded settings handed to the analog and output logic
  typedef struct packed {
    logic [10:0] sps;
    logic rate_valid;
    logic turbo;
    logic continuous;
    acr_ref_t ref_src;
    logic temp_mode;
    logic reg0_ignored;
    logic cnt_en;
    acr_integ_t integ;
    logic burnout_on;
    logic [10:0] burnout_ua;
    logic [10:0] current_ua;
    logic [5:0] route1;
    logic [5:0] route2;
    logic auto_out;
  } acr_ctrl_t;

endpackage : acr_pkg

// ### acr_conv_timer.sv
`timescale 1ns/1ps
`include "acr_defines.svh"
module acr_conv_timer
  import acr_pkg::*;
#(
  parameter int CONV_SHIFT = 0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mod_tick,
  input wire logic [2:0] rate_code,
  input wire logic rate_valid,
  input wire logic start,
  input wire logic continuous,
  output logic done,
  output logic busy
);

  if (CONV_SHIFT < 0 || CONV_SHIFT > 8)
  begin : g_chk
    $error("CONV_SHIFT out of range");
  end

  // Conversion length in modulator ticks, never below one
  function automatic logic [`ACR_TICKS_W-1:0] ticks_for(input logic [2:0] code);
    logic [`ACR_TICKS_W-1:0] t;
    t = `ACR_TICKS_6;
    case (code)
      3'h0: t = `ACR_TICKS_0;
      3'h1: t = `ACR_TICKS_1;
      3'h2: t = `ACR_TICKS_2;
      3'h3: t = `ACR_TICKS_3;
      3'h4: t = `ACR_TICKS_4;
      3'h5: t = `ACR_TICKS_5;
      default: t = `ACR_TICKS_6;
    endcase
    t = t >> CONV_SHIFT;
    if (t == '0)
      t = {{(`ACR_TICKS_W-1){1'b0}}, 1'b1};
    return t - 1'b1;
  endfunction : ticks_for

  acr_seq_t state_ff;
  logic [`ACR_TICKS_W-1:0] cnt_ff;
  logic done_ff;

  // Sequencer; a start with a legal rate code restarts the conversion, even while running
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ACR_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (start && rate_valid)
      begin
        state_ff <= ACR_RUN;
        cnt_ff <= ticks_for(rate_code);
      end
      else
      begin
        unique case (state_ff)
          ACR_IDLE: cnt_ff <= cnt_ff;
          ACR_RUN:
          begin
            if (mod_tick && cnt_ff == '0)
            begin
              done_ff <= 1'b1;
              cnt_ff <= ticks_for(rate_code);
              // Back-to-back only while continuous and rate legal
              if (!(continuous && rate_valid))
                state_ff <= ACR_IDLE;
            end
            else if (mod_tick)
              cnt_ff <= cnt_ff - 1'b1;
          end
        endcase
      end
    end
  end

  assign done = done_ff;
  assign busy = (state_ff == ACR_RUN);

endmodule : acr_conv_timer

// ### acr_host_model.sv
`timescale 1ns/1ps
module acr_host_model
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic conv_start,
  output logic result_read
);
  // Idle levels from time zero so the device never samples unknown strobes
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    conv_start = 1'b0;
    result_read = 1'b0;
  end

  // One register write; brk lets a test break the reserved-bit habit on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit brk);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == 8'h03 && !brk) ? (d & 8'hFD) : d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a; // Released lines do not keep the old value
    reg_wdata <= ~d;
  endtask : wr

  // One register read; data are taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd

  // Start or sync command
  task automatic start_conv;
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
  endtask : start_conv

  // Host fetches the conversion data
  task automatic read_result;
    @(posedge clk);
    result_read <= 1'b1;
    @(posedge clk);
    result_read <= 1'b0;
  endtask : read_result
endmodule : acr_host_model

// ### tb_acr_config_regs.sv
`timescale 1ns/1ps
module tb_acr_config_regs
  import acr_pkg::*;
;
  // Short divider and conversion counts keep the run brief
  localparam int DIV_N = 12;
  localparam int DIV_T = 9;
  localparam int SHIFT = 6;
  localparam int SPS_N [8] = '{20, 45, 90, 175, 330, 600, 1000, 0};
  localparam int SPS_T [8] = '{40, 90, 180, 350, 660, 1200, 2000, 0};
  localparam int CUR [8] = '{0, 10, 50, 100, 250, 500, 1000, 0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, conv_start, result_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, result_count;
  logic mod_tick, conv_busy, result_ready_flag, new_result, auto_send;
  acr_ctrl_t ctrl;
  int miscompares = 0;
  int total_checks = 0;
  int n;

  always #20 clk = ~clk;

  acr_config_regs #(.MOD_DIV_NORMAL(DIV_N), .MOD_DIV_TURBO(DIV_T), .CONV_SHIFT(SHIFT)) dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .result_read(result_read), .ctrl(ctrl), .mod_tick(mod_tick), .conv_busy(conv_busy),
    .result_ready_flag(result_ready_flag), .new_result(new_result), .auto_send(auto_send),
    .result_count(result_count));

  acr_host_model host (
    .clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .conv_start(conv_start), .result_read(result_read));

  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Let k edges pass and sample once their updates have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %0h", a), exp, d);
  endtask : rd_chk

  // Write then wait for the decoded settings to follow
  task automatic wr_set(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, 1'b0);
    cyc(2);
  endtask : wr_set

  // Cycles between two modulator ticks; the first gap after a change may be short
  task automatic gap(output int g);
    int i;
    for (i = 0; mod_tick !== 1'b1 && i < 500; i++) cyc(1);
    cyc(1);
    for (g = 1; mod_tick !== 1'b1 && g < 500; g++) cyc(1);
  endtask : gap

  // Bounded wait for the end-of-conversion pulse
  task automatic wait_new;
    int i;
    cyc(1);
    for (i = 0; new_result !== 1'b1 && i < 4000; i++) cyc(1);
    chk("new_result", 1, new_result);
  endtask : wait_new

  function automatic logic [5:0] onehot(input int c);
    return (c == 0 || c == 7) ? 6'h00 : 6'(1 << (c - 1));
  endfunction : onehot

  initial
  begin
    #400000;
    miscompares++;
    $display("watchdog expired");
    report_and_stop;
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) rd_chk(8'(a + 1), 8'h00);
    $display("test reset done");

    wr_set(8'h02, 8'hFF);
    host.wr(8'h03, 8'hFF, 1'b1);
    wr_set(8'h04, 8'hFF);
    rd_chk(8'h02, 8'h7F);
    rd_chk(8'h03, 8'hFD);
    rd_chk(8'h04, 8'h00);
    chk("cnt_en", 1, ctrl.cnt_en);
    chk("burnout_on", 1, ctrl.burnout_on);
    chk("burnout_ua", 32'h0000000A, ctrl.burnout_ua);
    chk("auto_out", 1, ctrl.auto_out);
    wr_set(8'h02, 8'h00);
    chk("cnt_en", 0, ctrl.cnt_en);
    chk("burnout_on", 0, ctrl.burnout_on);
    $display("test masks done");

    for (int t = 0; t < 2; t++)
      for (int c = 0; c < 8; c++)
      begin
        wr_set(8'h01, {c[2:0], t[0], 4'h0});
        chk("sps", t ? SPS_T[c] : SPS_N[c], ctrl.sps);
        chk("rate_valid", c != 7, ctrl.rate_valid);
        chk("turbo", t, ctrl.turbo);
      end
    for (int r = 0; r < 8; r++)
    begin
      wr_set(8'h01, 8'(r));
      chk("ref_src", r[0] ? 0 : (r >= 4 ? 2 : r[2:1]), ctrl.ref_src);
      chk("reg0_ignored", r[0], ctrl.reg0_ignored);
      chk("temp_mode", r[0], ctrl.temp_mode);
    end
    for (int k = 0; k < 8; k++)
    begin
      wr_set(8'h02, {2'b00, k[1:0], 1'b0, k[2:0]});
      chk("integ", k[1:0] == 2'b11 ? 0 : k[1:0], ctrl.integ);
      if (k < 7) chk("current_ua", CUR[k], ctrl.current_ua);
      wr_set(8'h03, {k[2:0], 3'(7 - k), 2'b00});
      chk("route1", onehot(k), ctrl.route1);
      chk("route2", onehot(7 - k), ctrl.route2);
    end
    $display("test decode done");

    wr_set(8'h01, 8'h00);
    gap(n);
    gap(n);
    chk("normal tick gap", DIV_N, n);
    wr_set(8'h01, 8'h10);
    gap(n);
    gap(n);
    chk("turbo tick gap", DIV_T, n);
    $display("test modulator done");

    wr_set(8'h02, 8'h40);
    wr_set(8'h03, 8'h01);
    wr_set(8'h01, 8'hC0);
    chk("continuous", 0, ctrl.continuous);
    host.start_conv;
    wait_new;
    chk("auto_send", 1, auto_send);
    chk("ready flag", 1, result_ready_flag);
    chk("count", 1, result_count);
    cyc(10);
    chk("busy single", 0, conv_busy);
    rd_chk(8'h02, 8'hC0);
    wr_set(8'h02, 8'h40);
    rd_chk(8'h02, 8'hC0);
    host.read_result;
    cyc(2);
    chk("ready flag", 0, result_ready_flag);
    wr_set(8'h03, 8'h00);
    wr_set(8'h01, 8'hC8);
    chk("continuous", 1, ctrl.continuous);
    host.start_conv;
    wait_new;
    chk("auto_send off", 0, auto_send);
    wait_new;
    chk("count", 3, result_count);
    wr_set(8'h01, 8'hE8);
    cyc(200);
    chk("busy reserved rate", 0, conv_busy);
    host.start_conv;
    cyc(20);
    chk("busy refused start", 0, conv_busy);
    $display("test conversion done");
    report_and_stop;
  end
endmodule : tb_acr_config_regs
